// *** tsrl_defines.vh ***
// Pointer map, field masks, reset values and identity codes of the temperature register bank
`ifndef TSRL_DEFINES_VH
`define TSRL_DEFINES_VH

// ----------------------------------------
// Read pointers
// ----------------------------------------
`define TSRL_RD_LT_MSB 8'h00
`define TSRL_RD_RT_MSB 8'h01
`define TSRL_RD_STATUS 8'h02
`define TSRL_RD_CFG 8'h03
`define TSRL_RD_RATE 8'h04
`define TSRL_RD_LUB_MSB 8'h05
`define TSRL_RD_LLB_MSB 8'h06
`define TSRL_RD_RUB_MSB 8'h07
`define TSRL_RD_RLB_MSB 8'h08
`define TSRL_RD_RT_LSB 8'h10
`define TSRL_RD_LT_LSB 8'h15
`define TSRL_RD_MAKER 8'hFE
`define TSRL_RD_PART 8'hFF

// ----------------------------------------
// Write pointers
// ----------------------------------------
`define TSRL_WR_CFG 8'h09
`define TSRL_WR_RATE 8'h0A
`define TSRL_WR_LUB_MSB 8'h0B
`define TSRL_WR_LLB_MSB 8'h0C
`define TSRL_WR_RUB_MSB 8'h0D
`define TSRL_WR_RLB_MSB 8'h0E
`define TSRL_WR_ONESHOT 8'h0F

// ----------------------------------------
// Pointers shared by read and write
// ----------------------------------------
`define TSRL_RUB_LSB 8'h13
`define TSRL_RLB_LSB 8'h14
`define TSRL_LUB_LSB 8'h16
`define TSRL_LLB_LSB 8'h17
`define TSRL_RCRIT 8'h19
`define TSRL_RES 8'h1A
`define TSRL_LCRIT 8'h20
`define TSRL_HYST 8'h21
`define TSRL_FCNT 8'h22

// ----------------------------------------
// Reset values and field layout
// ----------------------------------------
`define TSRL_PTR_RST 8'h00
`define TSRL_TEMP_RST 12'h000
`define TSRL_UB_RST 12'h550
`define TSRL_LB_RST 12'h000
`define TSRL_CRIT_RST 8'h55
`define TSRL_HYST_RST 8'h0A
`define TSRL_CFG_RST 8'h00
`define TSRL_RATE_RST 4'h8
`define TSRL_RES_RST 2'h0
`define TSRL_FCNT_RST 8'h80
`define TSRL_CFG_MASK 8'hE4
`define TSRL_FCNT_MASK 8'h8E
`define TSRL_RES_FIXED 6'h07
`define TSRL_RANGE_BIT 2
`define TSRL_EXT_OFFSET 10'h040
`define TSRL_STD_MAX 8'h7F
`define TSRL_EXT_MAX 8'hFF
`define TSRL_MAKER_ID 8'hA0
`define TSRL_PART_ID 8'h0B

`endif

// *** tsrl_regs.v ***
// Pointer-addressed result, limit and setting registers of a two-channel temperature monitor
`timescale 1ns/10ps
`include "tsrl_defines.vh"

module tsrl_regs (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Byte interface from the two-wire protocol engine
    input wire ptr_load,
    input wire [7:0] ptr_byte,
    input wire wr_stb,
    input wire [7:0] wr_byte,
    input wire rd_stb,
    output reg [7:0] rd_byte,
    output reg rd_ack,
    input wire xfer_end,
    // Converter side
    input wire conv_done,
    input wire [12:0] local_raw,
    input wire [12:0] remote_raw,
    input wire [7:0] status_bits,
    output reg status_rd,
    output reg one_shot,
    // Stored values for the comparators and the converter
    output reg [11:0] local_reading_bits,
    output reg [11:0] remote_reading_bits,
    output reg [11:0] local_upper_bound_bits,
    output reg [11:0] local_lower_bound_bits,
    output reg [11:0] remote_upper_bound_bits,
    output reg [11:0] remote_lower_bound_bits,
    output reg [7:0] local_critical_bits,
    output reg [7:0] remote_critical_bits,
    output reg [7:0] critical_hysteresis_bits,
    output reg [7:0] device_config,
    output reg [3:0] sample_rate_select,
    output reg local_fraction_sel_hi,
    output reg local_fraction_sel_lo,
    output reg [7:0] fault_count_setting
);

    // ----------------------------------------
    // Overview
    // ----------------------------------------
    // The protocol engine hands over whole bytes. A write command starts with the
    // pointer byte and may carry data bytes after it. A read command uses the pointer
    // that the last write command left behind.
    // Within one command the first data byte goes to the register the pointer names. Every later
    // byte goes to the low half of the register pair when the pointer names one.
    // The pointer is never incremented, so a longer burst keeps hitting that low half.
    // Upper and lower limits are kept as twelve bits: the integer byte on top and the upper nibble
    // of the low byte below it. The unused low nibble always reads as zero.
    // Results are kept in the same way. The stored byte is already clamped to the
    // range format that was selected when the conversion landed.
    // The low-byte snapshot is what keeps a high/low read pair coherent. It is only
    // released by a read of some other register, never by a write, because a host
    // has to write the pointer before every read.
    // Reads never disturb stored data. Only the status read is signalled outward,
    // so that the flag logic outside can clear its latched bits.

    // ----------------------------------------
    // Transfer state
    // ----------------------------------------
    reg [7:0] ptr;
    reg rd_second;
    reg wr_second;
    reg [3:0] shadow_lsb;
    reg shadow_valid;
    reg shadow_remote;

    wire [7:0] rd_addr;
    wire [7:0] wr_addr;
    wire ext_range;
    wire rd_is_lt_msb;
    wire rd_is_rt_msb;
    wire rd_is_lt_lsb;
    wire rd_is_rt_lsb;
    reg [7:0] rd_mux;
    reg [3:0] frac_mask;

    // ----------------------------------------
    // Second-byte address of a register pair
    // ----------------------------------------
    // Read and write pointers of the pairs never collide, so one table serves both.
    // Pointers that are not the upper half of a pair map to themselves; a burst at
    // such a pointer therefore reads or writes the same register again.
    function [7:0] pair_lsb;
        input [7:0] a;
        begin
            case (a)
                `TSRL_RD_LT_MSB: pair_lsb = `TSRL_RD_LT_LSB;
                `TSRL_RD_RT_MSB: pair_lsb = `TSRL_RD_RT_LSB;
                `TSRL_RD_LUB_MSB: pair_lsb = `TSRL_LUB_LSB;
                `TSRL_RD_LLB_MSB: pair_lsb = `TSRL_LLB_LSB;
                `TSRL_RD_RUB_MSB: pair_lsb = `TSRL_RUB_LSB;
                `TSRL_RD_RLB_MSB: pair_lsb = `TSRL_RLB_LSB;
                `TSRL_WR_LUB_MSB: pair_lsb = `TSRL_LUB_LSB;
                `TSRL_WR_LLB_MSB: pair_lsb = `TSRL_LLB_LSB;
                `TSRL_WR_RUB_MSB: pair_lsb = `TSRL_RUB_LSB;
                `TSRL_WR_RLB_MSB: pair_lsb = `TSRL_RLB_LSB;
                default: pair_lsb = a;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Integer byte of a conversion result
    // ----------------------------------------
    // Raw input is signed, 1/16 degree per step; out-of-range values saturate.
    // The standard format cannot show anything below zero or above 127.
    // The extended format adds a fixed offset so that negative readings fit,
    // and it saturates at the top of the byte.
    // The fraction nibble is never clamped; only the integer byte is.
    function [7:0] fmt_msb;
        input [12:0] raw;
        input ext;
        reg [9:0] t;
        begin
            t = {raw[12], raw[12:4]};
            if (ext) begin
                t = t + `TSRL_EXT_OFFSET;
            end
            if (t[9]) begin
                fmt_msb = 8'h00;
            end else if (ext && t[8]) begin
                fmt_msb = `TSRL_EXT_MAX;
            end else if (!ext && (t[8] || t[7])) begin
                fmt_msb = `TSRL_STD_MAX;
            end else begin
                fmt_msb = t[7:0];
            end
        end
    endfunction

    assign ext_range = device_config[`TSRL_RANGE_BIT];
    assign rd_addr = rd_second ? pair_lsb(ptr) : ptr;
    assign wr_addr = wr_second ? pair_lsb(ptr) : ptr;
    assign rd_is_lt_msb = (rd_addr == `TSRL_RD_LT_MSB);
    assign rd_is_rt_msb = (rd_addr == `TSRL_RD_RT_MSB);
    assign rd_is_lt_lsb = (rd_addr == `TSRL_RD_LT_LSB);
    assign rd_is_rt_lsb = (rd_addr == `TSRL_RD_RT_LSB);

    // ----------------------------------------
    // Local fraction resolution
    // ----------------------------------------
    // Coarser settings drop the finer fraction bits at store time, so a
    // later change of resolution does not alter results already stored.
    // The remote channel has no such setting.
    always @* begin
        case ({local_fraction_sel_hi, local_fraction_sel_lo})
            2'h0: frac_mask = 4'h8;
            2'h1: frac_mask = 4'hC;
            2'h2: frac_mask = 4'hE;
            default: frac_mask = 4'hF;
        endcase
    end

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    // Write-only and unmapped pointers read as zero.
    // The low result bytes prefer the snapshot of their own channel; the live
    // nibble is shown when the snapshot is invalid or belongs to the other channel.
    always @* begin
        case (rd_addr)
            `TSRL_RD_LT_MSB: rd_mux = local_reading_bits[11:4];
            `TSRL_RD_RT_MSB: rd_mux = remote_reading_bits[11:4];
            `TSRL_RD_LT_LSB: begin
                if (shadow_valid && !shadow_remote) begin
                    rd_mux = {shadow_lsb, 4'h0};
                end else begin
                    rd_mux = {local_reading_bits[3:0], 4'h0};
                end
            end
            `TSRL_RD_RT_LSB: begin
                if (shadow_valid && shadow_remote) begin
                    rd_mux = {shadow_lsb, 4'h0};
                end else begin
                    rd_mux = {remote_reading_bits[3:0], 4'h0};
                end
            end
            `TSRL_RD_STATUS: rd_mux = status_bits;
            `TSRL_RD_CFG: rd_mux = device_config;
            `TSRL_RD_RATE: rd_mux = {4'h0, sample_rate_select};
            `TSRL_RD_LUB_MSB: rd_mux = local_upper_bound_bits[11:4];
            `TSRL_RD_LLB_MSB: rd_mux = local_lower_bound_bits[11:4];
            `TSRL_RD_RUB_MSB: rd_mux = remote_upper_bound_bits[11:4];
            `TSRL_RD_RLB_MSB: rd_mux = remote_lower_bound_bits[11:4];
            `TSRL_LUB_LSB: rd_mux = {local_upper_bound_bits[3:0], 4'h0};
            `TSRL_LLB_LSB: rd_mux = {local_lower_bound_bits[3:0], 4'h0};
            `TSRL_RUB_LSB: rd_mux = {remote_upper_bound_bits[3:0], 4'h0};
            `TSRL_RLB_LSB: rd_mux = {remote_lower_bound_bits[3:0], 4'h0};
            `TSRL_RCRIT: rd_mux = remote_critical_bits;
            `TSRL_LCRIT: rd_mux = local_critical_bits;
            `TSRL_HYST: rd_mux = critical_hysteresis_bits;
            `TSRL_RES: rd_mux = {`TSRL_RES_FIXED, local_fraction_sel_hi, local_fraction_sel_lo};
            `TSRL_FCNT: rd_mux = fault_count_setting;
            `TSRL_RD_MAKER: rd_mux = `TSRL_MAKER_ID;
            `TSRL_RD_PART: rd_mux = `TSRL_PART_ID;
            default: rd_mux = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Pointer and byte position in a transfer
    // ----------------------------------------
    // The byte position is cleared both by a new pointer and by the end of a
    // command, so a read that follows a write starts again at the pointer.
    always @(posedge mclk) begin
        if (reset) begin
            ptr <= `TSRL_PTR_RST;
            rd_second <= 1'b0;
            wr_second <= 1'b0;
        end else begin
            if (ptr_load) begin
                ptr <= ptr_byte;
            end
            if (ptr_load || xfer_end) begin
                rd_second <= 1'b0;
                wr_second <= 1'b0;
            end else begin
                if (rd_stb) begin
                    rd_second <= 1'b1;
                end
                if (wr_stb) begin
                    wr_second <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Read answer and low-byte snapshot
    // ----------------------------------------
    // The snapshot is taken from the stored low nibble in the same edge the high byte
    // is answered, so a conversion landing in between cannot tear the pair.
    // A low-byte read of the same channel keeps the snapshot, so that the low
    // byte may be read again with the same result.
    always @(posedge mclk) begin
        if (reset) begin
            rd_byte <= 8'h00;
            rd_ack <= 1'b0;
            status_rd <= 1'b0;
            shadow_lsb <= 4'h0;
            shadow_valid <= 1'b0;
            shadow_remote <= 1'b0;
        end else begin
            rd_ack <= rd_stb;
            status_rd <= rd_stb && (rd_addr == `TSRL_RD_STATUS);
            if (rd_stb) begin
                rd_byte <= rd_mux;
                if (rd_is_lt_msb) begin
                    shadow_lsb <= local_reading_bits[3:0];
                    shadow_valid <= 1'b1;
                    shadow_remote <= 1'b0;
                end else if (rd_is_rt_msb) begin
                    shadow_lsb <= remote_reading_bits[3:0];
                    shadow_valid <= 1'b1;
                    shadow_remote <= 1'b1;
                end else if (rd_is_lt_lsb && !shadow_remote) begin
                    shadow_valid <= shadow_valid;
                end else if (rd_is_rt_lsb && shadow_remote) begin
                    shadow_valid <= shadow_valid;
                end else begin
                    shadow_valid <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Conversion results
    // ----------------------------------------
    // Stored results follow the range bit at the moment of each conversion.
    // Results stored before a range change keep their old format until the
    // next conversion overwrites them.
    always @(posedge mclk) begin
        if (reset) begin
            local_reading_bits <= `TSRL_TEMP_RST;
            remote_reading_bits <= `TSRL_TEMP_RST;
        end else if (conv_done) begin
            local_reading_bits[11:4] <= fmt_msb(local_raw, ext_range);
            local_reading_bits[3:0] <= local_raw[3:0] & frac_mask;
            remote_reading_bits[11:4] <= fmt_msb(remote_raw, ext_range);
            remote_reading_bits[3:0] <= remote_raw[3:0];
        end
    end

    // ----------------------------------------
    // Host-written registers
    // ----------------------------------------
    // A range change leaves every limit untouched; software rewrites them itself.
    // Writes to read-only or unmapped pointers are dropped without any sign.
    // Reserved bits of the setting registers are masked off at write time.
    always @(posedge mclk) begin
        if (reset) begin
            local_upper_bound_bits <= `TSRL_UB_RST;
            remote_upper_bound_bits <= `TSRL_UB_RST;
            local_lower_bound_bits <= `TSRL_LB_RST;
            remote_lower_bound_bits <= `TSRL_LB_RST;
            local_critical_bits <= `TSRL_CRIT_RST;
            remote_critical_bits <= `TSRL_CRIT_RST;
            critical_hysteresis_bits <= `TSRL_HYST_RST;
            device_config <= `TSRL_CFG_RST;
            sample_rate_select <= `TSRL_RATE_RST;
            {local_fraction_sel_hi, local_fraction_sel_lo} <= `TSRL_RES_RST;
            fault_count_setting <= `TSRL_FCNT_RST;
            one_shot <= 1'b0;
        end else begin
            one_shot <= wr_stb && (wr_addr == `TSRL_WR_ONESHOT);
            if (wr_stb) begin
                case (wr_addr)
                    `TSRL_WR_CFG: device_config <= wr_byte & `TSRL_CFG_MASK;
                    `TSRL_WR_RATE: sample_rate_select <= wr_byte[3:0];
                    `TSRL_WR_LUB_MSB: local_upper_bound_bits[11:4] <= wr_byte;
                    `TSRL_WR_LLB_MSB: local_lower_bound_bits[11:4] <= wr_byte;
                    `TSRL_WR_RUB_MSB: remote_upper_bound_bits[11:4] <= wr_byte;
                    `TSRL_WR_RLB_MSB: remote_lower_bound_bits[11:4] <= wr_byte;
                    `TSRL_LUB_LSB: local_upper_bound_bits[3:0] <= wr_byte[7:4];
                    `TSRL_LLB_LSB: local_lower_bound_bits[3:0] <= wr_byte[7:4];
                    `TSRL_RUB_LSB: remote_upper_bound_bits[3:0] <= wr_byte[7:4];
                    `TSRL_RLB_LSB: remote_lower_bound_bits[3:0] <= wr_byte[7:4];
                    `TSRL_RCRIT: remote_critical_bits <= wr_byte;
                    `TSRL_LCRIT: local_critical_bits <= wr_byte;
                    `TSRL_HYST: critical_hysteresis_bits <= wr_byte;
                    `TSRL_RES: {local_fraction_sel_hi, local_fraction_sel_lo} <= wr_byte[1:0];
                    `TSRL_FCNT: fault_count_setting <= wr_byte & `TSRL_FCNT_MASK;
                    default: device_config <= device_config;
                endcase
            end
        end
    end

endmodule

// *** tsrl_regs_asserts.sv ***
// Concurrent checks on the ports of the temperature register bank
`timescale 1ns/10ps

module tsrl_asserts (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Byte interface
    input wire ptr_load,
    input wire [7:0] ptr_byte,
    input wire wr_stb,
    input wire [7:0] wr_byte,
    input wire rd_stb,
    input wire rd_ack,
    input wire one_shot,
    // Converter and stored values
    input wire conv_done,
    input wire [12:0] remote_raw,
    input wire [11:0] local_reading_bits,
    input wire [11:0] remote_reading_bits,
    input wire [11:0] local_upper_bound_bits,
    input wire [11:0] local_lower_bound_bits,
    input wire [11:0] remote_upper_bound_bits,
    input wire [7:0] local_critical_bits,
    input wire [7:0] critical_hysteresis_bits
);
    // Slice kept apart so the sampled-value call sees a plain signal
    wire [3:0] raw_frac = remote_raw[3:0];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    chk_ack_follows_read: assert property (rd_stb |=> rd_ack)
        else $error("read strobe not answered next cycle");
    chk_no_stray_ack: assert property (!rd_stb |=> !rd_ack)
        else $error("answer without read strobe");
    chk_results_steady: assert property (!conv_done |=> $stable(local_reading_bits)
        && $stable(remote_reading_bits))
        else $error("result changed without conversion");
    chk_remote_frac: assert property (conv_done |=> remote_reading_bits[3:0] == $past(raw_frac))
        else $error("remote fraction not taken whole");
    chk_reset_vals: assert property ($fell(reset) |-> local_upper_bound_bits == 12'h550
        && remote_upper_bound_bits == 12'h550 && local_lower_bound_bits == 12'h000
        && local_critical_bits == 8'h55 && critical_hysteresis_bits == 8'h0A)
        else $error("bad value after reset");
    chk_crit_write: assert property (ptr_load && ptr_byte == 8'h20 ##1 wr_stb
        |=> local_critical_bits == $past(wr_byte))
        else $error("local critical limit not written");
    chk_hyst_write: assert property (ptr_load && ptr_byte == 8'h21 ##1 wr_stb
        |=> critical_hysteresis_bits == $past(wr_byte))
        else $error("hysteresis not written");
    chk_pair_write: assert property (ptr_load && ptr_byte == 8'h0B ##1 wr_stb ##1 wr_stb
        |=> local_upper_bound_bits[11:4] == $past(wr_byte, 2)
        && local_upper_bound_bits[3:0] == $past(wr_byte[7:4]))
        else $error("two-byte limit write misrouted");
    chk_one_shot: assert property (ptr_load && ptr_byte == 8'h0F ##1 wr_stb |=> one_shot)
        else $error("single conversion trigger missing");
endmodule

bind tsrl_regs tsrl_asserts i_chk (
    .mclk(mclk), .reset(reset), .ptr_load(ptr_load), .ptr_byte(ptr_byte),
    .wr_stb(wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb), .rd_ack(rd_ack),
    .one_shot(one_shot), .conv_done(conv_done), .remote_raw(remote_raw),
    .local_reading_bits(local_reading_bits), .remote_reading_bits(remote_reading_bits),
    .local_upper_bound_bits(local_upper_bound_bits),
    .local_lower_bound_bits(local_lower_bound_bits),
    .remote_upper_bound_bits(remote_upper_bound_bits),
    .local_critical_bits(local_critical_bits),
    .critical_hysteresis_bits(critical_hysteresis_bits)
);

// *** tsrl_host.sv ***
// Two-wire host model issuing pointer, write and read commands
`timescale 1ns/10ps

module tsrl_host (
    // Clock
    input wire mclk,
    // Command side
    output reg ptr_load,
    output reg [7:0] ptr_byte,
    output reg wr_stb,
    output reg [7:0] wr_byte,
    output reg rd_stb,
    output reg xfer_end,
    // Answer side
    input wire [7:0] rd_byte,
    input wire rd_ack
);
    initial begin
        ptr_load = 1'b0; ptr_byte = 8'h00; wr_stb = 1'b0;
        wr_byte = 8'h00; rd_stb = 1'b0; xfer_end = 1'b0;
    end

    // Every write command loads the pointer first; reads use the last pointer
    task wr_cmd(input [7:0] p, input integer n, input [15:0] d);
        integer i;
        begin
            @(posedge mclk);
            ptr_load <= 1'b1;
            ptr_byte <= p;
            for (i = 0; i < n; i++) begin
                @(posedge mclk);
                ptr_load <= 1'b0;
                wr_stb <= 1'b1;
                wr_byte <= (i == 0) ? d[15:8] : d[7:0];
            end
            @(posedge mclk);
            ptr_load <= 1'b0;
            wr_stb <= 1'b0;
            xfer_end <= 1'b1;
            // Released lines never keep the last value
            ptr_byte <= ~p;
            wr_byte <= ~wr_byte;
            @(posedge mclk);
            xfer_end <= 1'b0;
        end
    endtask

    // High byte comes out first when n is two
    task rd_cmd(input integer n, output [15:0] d);
        integer i;
        integer k;
        begin
            d = 16'h0000;
            for (i = 0; i < n; i++) begin
                @(posedge mclk);
                rd_stb <= 1'b1;
                @(posedge mclk);
                rd_stb <= 1'b0;
                for (k = 0; k < 4 && rd_ack !== 1'b1; k++)
                    @(posedge mclk);
                d = (rd_ack === 1'b1) ? {d[7:0], rd_byte} : 16'hxxxx;
            end
            @(posedge mclk);
            xfer_end <= 1'b1;
            @(posedge mclk);
            xfer_end <= 1'b0;
        end
    endtask
endmodule

// *** temp_sensor_result_limit_regs_tb.sv ***
// Self-checking bench for the temperature register bank
`timescale 1ns/10ps

module temp_sensor_result_limit_regs_tb;
    reg mclk = 1'b0;
    reg reset = 1'b1;
    reg conv_done = 1'b0;
    reg [12:0] local_raw = 13'h0000;
    reg [12:0] remote_raw = 13'h0000;
    reg [7:0] status_bits = 8'h00;
    wire ptr_load, wr_stb, rd_stb, xfer_end, rd_ack;
    wire [7:0] ptr_byte, wr_byte, rd_byte;
    integer errors = 0;
    integer tests_run = 0;
    integer cyc = 0;
    integer i, j, m;
    reg [7:0] h, l;
    reg [12:0] a, b, c;
    reg [15:0] lim [0:3];
    reg [7:0] rp [0:14] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h13, 8'h14, 8'h16, 8'h17,
                            8'h19, 8'h20, 8'h21, 8'h00, 8'h01, 8'h10, 8'h15};
    reg [7:0] rv [0:14] = '{8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'h55, 8'h55, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h00};
    reg [7:0] wp [0:3] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E};
    reg [7:0] lp [0:3] = '{8'h16, 8'h17, 8'h13, 8'h14};
    reg [7:0] cp [0:2] = '{8'h20, 8'h19, 8'h21};

    always #10 mclk = ~mclk;

    tsrl_host i_host (.mclk(mclk), .ptr_load(ptr_load), .ptr_byte(ptr_byte),
        .wr_stb(wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb), .xfer_end(xfer_end),
        .rd_byte(rd_byte), .rd_ack(rd_ack));

    tsrl_regs i_dut (.mclk(mclk), .reset(reset), .ptr_load(ptr_load), .ptr_byte(ptr_byte),
        .wr_stb(wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb), .rd_byte(rd_byte),
        .rd_ack(rd_ack), .xfer_end(xfer_end), .conv_done(conv_done),
        .local_raw(local_raw), .remote_raw(remote_raw), .status_bits(status_bits),
        .status_rd(), .one_shot(), .local_reading_bits(), .remote_reading_bits(),
        .local_upper_bound_bits(), .local_lower_bound_bits(), .remote_upper_bound_bits(),
        .remote_lower_bound_bits(), .local_critical_bits(), .remote_critical_bits(),
        .critical_hysteresis_bits(), .device_config(), .sample_rate_select(),
        .local_fraction_sel_hi(), .local_fraction_sel_lo(), .fault_count_setting());

    // Whole degrees, clamped to the range that the format can hold
    function [7:0] exp_hi(input [12:0] r, input ext);
        integer t;
        begin
            t = $signed(r[12:4]) + (ext ? 64 : 0);
            if (t < 0) t = 0;
            if (t > (ext ? 255 : 127)) t = ext ? 255 : 127;
            exp_hi = t[7:0];
        end
    endfunction

    task stop_test;
        begin
            if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task rd(input [7:0] p, input integer n, input [15:0] e);
        reg [15:0] d;
        begin
            i_host.wr_cmd(p, 0, 16'h0000);
            i_host.rd_cmd(n, d);
            tests_run++;
            if (d !== e) begin
                errors++;
                $display("CHECK FAILED ptr %h expected %h seen %h", p, e, d);
            end
        end
    endtask

    task conv(input [12:0] lr, input [12:0] rr);
        begin
            @(posedge mclk);
            conv_done <= 1'b1;
            local_raw <= lr;
            remote_raw <= rr;
            @(posedge mclk);
            conv_done <= 1'b0;
            local_raw <= ~lr;
            remote_raw <= ~rr;
        end
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            errors++;
            stop_test;
        end
    end

    initial begin
        h = $urandom(49948);
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        for (i = 0; i < 15; i++) rd(rp[i], 1, {8'h00, rv[i]});
        i_host.wr_cmd(8'h0F, 1, 16'hA500);
        rd(8'h0F, 1, 16'h0000);
        rd(8'h30, 1, 16'h0000);
        i_host.wr_cmd(8'h00, 1, 16'h7F00);
        rd(8'h00, 1, 16'h0000);
        for (j = 0; j < 4; j++) begin
            h = $urandom;
            l = $urandom;
            i_host.wr_cmd(wp[j], 2, {h, l});
            rd(wp[j] - 8'h06, 2, {h, l & 8'hF0});
            l = $urandom;
            i_host.wr_cmd(lp[j], 1, {l, 8'h00});
            lim[j] = {h, l & 8'hF0};
            rd(lp[j], 1, {8'h00, lim[j][7:0]});
        end
        for (j = 0; j < 3; j++) begin
            h = $urandom;
            i_host.wr_cmd(cp[j], 1, {h, 8'h00});
            rd(cp[j], 1, {8'h00, h});
        end
        for (m = 0; m < 2; m++) begin
            i_host.wr_cmd(8'h09, 1, {m ? 8'h04 : 8'h00, 8'h00});
            rd(8'h03, 1, {8'h00, m ? 8'h04 : 8'h00});
            for (j = 0; j < 4; j++) begin
                a = (j == 0) ? 13'h1FF0 : $urandom;
                b = (j == 0) ? 13'h0FFF : $urandom;
                conv(a, b);
                rd(8'h00, 2, {exp_hi(a, m), a[3], 7'h00});
                rd(8'h01, 1, {8'h00, exp_hi(b, m)});
                rd(8'h10, 1, {8'h00, b[3:0], 4'h0});
            end
            rd(8'h05, 2, lim[0]);
        end
        i_host.wr_cmd(8'h1A, 1, 16'h0300);
        rd(8'h1A, 1, 16'h001F);
        a = $urandom;
        b = $urandom;
        conv(a, b);
        rd(8'h15, 1, {8'h00, a[3:0], 4'h0});
        a = $urandom;
        b = $urandom;
        c = $urandom;
        conv(a, b);
        rd(8'h01, 1, {8'h00, exp_hi(b, 1'b1)});
        conv(a, c);
        rd(8'h10, 1, {8'h00, b[3:0], 4'h0});
        rd(8'h01, 1, {8'h00, exp_hi(c, 1'b1)});
        rd(8'h07, 2, lim[2]);
        conv(a, b);
        rd(8'h10, 1, {8'h00, b[3:0], 4'h0});
        stop_test;
    end
endmodule
